/* rtl/gdop_top.sv */
// Ground data output port of the flight data adapter: ground handshake,
// output word multiplexer with computer pre-emption, ground and telemetry words.
// Assumes all ground and command-system pins are asynchronous to ref_clk_i.
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module gdop_top
    import gdop_pkg::*;
#(
    parameter int HS_HOLD_CYCLES = gdop_pkg::HS_CYCLES
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [gdop_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic initialise_i,
    input wire logic command_source_select_i,
    input wire logic word_read_strobe_i,
    input wire logic ground_sync_bit_i,
    input wire logic release_alert_i,
    input wire logic guidance_reference_release_i,
    input wire logic [gdop_pkg::GDATA_W-1:0] ground_data_i,
    input wire logic command_sync_i,
    input wire logic [gdop_pkg::GDATA_W-1:0] command_data_i,
    output logic transfer_handshake_reset_o,
    output logic prelaunch_mode_o,
    output logic guidance_failure_flag_o,
    output logic [gdop_pkg::DATA_W-1:0] ground_word_o,
    output logic [gdop_pkg::TAG_W-1:0] ground_tag_o,
    output logic [gdop_pkg::MODE_W-1:0] ground_mode_o,
    output logic ground_real_time_o,
    output logic [gdop_pkg::DATA_W-1:0] tlm_word_o,
    output logic [gdop_pkg::TAG_W-1:0] tlm_tag_o,
    output logic tlm_tag_shared_bit_o,
    output logic [gdop_pkg::TLM_MODE_W-1:0] tlm_mode_rt_o,
    output logic tlm_valid_rt_o
);
    import gdop_pkg::*;

    // Two-stage synchronisers; only the second stage is read by logic.
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
    logic sync_d;
    logic strobe_d;
    logic release_d;
    wire [SYNC_W-1:0] pins = {initialise_i, command_source_select_i, word_read_strobe_i,
        guidance_reference_release_i, ground_sync_bit_i, release_alert_i,
        command_sync_i, ground_data_i, command_data_i};

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta <= '0;
            sync <= '0;
        end
        else
        begin
            meta <= pins;
            sync <= meta;
        end
    end

    wire init_s = sync[SYNC_W-1];
    wire select_s = sync[SYNC_W-2];
    wire strobe_s = sync[SYNC_W-3];
    wire release_s = sync[SYNC_W-4];
    wire gsync_s = sync[SYNC_W-5];
    wire alert_s = sync[SYNC_W-6];
    wire csync_s = sync[SYNC_W-7];
    wire [GDATA_W-1:0] gdata_s = sync[2*GDATA_W-1:GDATA_W];
    wire [GDATA_W-1:0] cdata_s = sync[GDATA_W-1:0];

    // Source gating between ground equipment and on-board command system.
    wire sel_sync = select_s ? csync_s : gsync_s;
    wire [GDATA_W-1:0] sel_data = select_s ? cdata_s : gdata_s;
    wire sync_rise = sel_sync & ~sync_d;
    wire strobe_rise = strobe_s & ~strobe_d;
    wire release_rise = release_s & ~release_d;

    // Register bus decode.
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i & ~init_s;
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire wr_ctrl = bus_wr && wb_adr_i == ADR_CTRL;
    wire wr_mode = bus_wr && wb_adr_i == ADR_MODE_RT;
    wire wr_mux_tag = bus_wr && wb_adr_i == ADR_MUX_TAG;
    wire wr_mux_data = bus_wr && wb_adr_i == ADR_MUX_DATA;
    wire wr_pio_tag = bus_wr && wb_adr_i == ADR_PIO_TAG;
    wire wr_pio_data = bus_wr && wb_adr_i == ADR_PIO_DATA;
    wire wr_status = bus_wr && wb_adr_i == ADR_STATUS;

    logic [31:0] ctrl;
    logic [31:0] mode_rt;
    logic [31:0] mux_tag;
    logic [31:0] pio_tag;
    wire [31:0] next_ctrl = (ctrl & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] next_mode_rt = (mode_rt & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] next_mux_tag = (mux_tag & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] next_pio_tag = (pio_tag & ~wmask) | (wb_dat_i & wmask);
    wire go_pulse = wr_ctrl & wb_dat_i[CTRL_GO] & wb_sel_i[0];
    wire [MODE_W-1:0] mode_f = mode_rt[MODE_W-1:0];
    wire [RT_W-1:0] rt_f = mode_rt[RT_LSB +: RT_W];

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl <= '0;
            mode_rt <= '0;
            mux_tag <= '0;
            pio_tag <= '0;
        end
        else if (init_s)
        begin
            ctrl <= '0;
            mode_rt <= '0;
            mux_tag <= '0;
            pio_tag <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= next_ctrl & ~(32'h1 << CTRL_GO);
            if (wr_mode)
                mode_rt <= next_mode_rt;
            if (wr_mux_tag)
                mux_tag <= next_mux_tag;
            if (wr_pio_tag)
                pio_tag <= next_pio_tag;
        end
    end

    // Ground word capture and handshake reset sequencer.
    gdop_hs_t hs_state;
    gdop_hs_t next_hs_state;
    logic [HS_CNT_W-1:0] hs_cnt;
    logic [INFO_W:0] gword;
    logic mode_valid;
    logic started;
    logic alert_seen;
    logic prelaunch;
    wire hs_last = hs_cnt == HS_CNT_W'(HS_HOLD_CYCLES - 1);
    wire clr_started = wr_status & wb_dat_i[ST_STARTED] & wb_sel_i[0];

    always_comb
    begin
        next_hs_state = hs_state;
        case (hs_state)
            HS_IDLE:
                if (sync_rise)
                    next_hs_state = ctrl[CTRL_READOUT] ? HS_ARMED : HS_HOLD;
            HS_ARMED:
                if (go_pulse)
                    next_hs_state = HS_HOLD;
            HS_HOLD:
                if (hs_last)
                    next_hs_state = HS_IDLE;
            default:
                next_hs_state = HS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hs_state <= HS_IDLE;
            hs_cnt <= '0;
            gword <= '0;
            mode_valid <= 1'b0;
            started <= 1'b0;
            alert_seen <= 1'b0;
            prelaunch <= 1'b0;
            sync_d <= 1'b0;
            strobe_d <= 1'b0;
            release_d <= 1'b0;
        end
        else if (init_s)
        begin
            hs_state <= HS_IDLE;
            hs_cnt <= '0;
            gword <= '0;
            mode_valid <= 1'b0;
            started <= 1'b0;
            alert_seen <= 1'b0;
            prelaunch <= 1'b0;
            sync_d <= sel_sync;
            strobe_d <= strobe_s;
            release_d <= release_s;
        end
        else
        begin
            hs_state <= next_hs_state;
            sync_d <= sel_sync;
            strobe_d <= strobe_s;
            release_d <= release_s;
            hs_cnt <= (hs_state == HS_HOLD && !hs_last) ? hs_cnt + 1'b1 : '0;
            if (sync_rise && hs_state == HS_IDLE)
            begin
                gword <= sel_data;
                mode_valid <= sel_data[FLAG_BIT];
            end
            if (hs_state == HS_HOLD && hs_last)
                started <= 1'b1;
            else if (clr_started)
                started <= 1'b0;
            if (alert_s)
                alert_seen <= 1'b1;
            if (release_rise && alert_seen)
                prelaunch <= 1'b1;
        end
    end

    // Output buffer, multiplexer delay-line word and displaced-word store.
    logic [DATA_W-1:0] buf_data;
    logic [8:0] buf_tag;
    logic buf_pio;
    logic buf_read;
    logic [DATA_W-1:0] mux_data;
    logic mux_pend;
    logic [DATA_W-1:0] disp_data;
    logic [8:0] disp_tag;
    logic disp_valid;
    logic loading;
    wire preempt = wr_pio_data & ~buf_pio & ~buf_read;
    wire from_disp = strobe_rise & disp_valid & buf_pio;
    wire from_mux = strobe_rise & ~from_disp & mux_pend;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            buf_data <= '0;
            buf_tag <= '0;
            buf_pio <= 1'b0;
            buf_read <= 1'b0;
            mux_data <= '0;
            mux_pend <= 1'b0;
            disp_data <= '0;
            disp_tag <= '0;
            disp_valid <= 1'b0;
            loading <= 1'b0;
        end
        else if (init_s)
        begin
            buf_data <= '0;
            buf_tag <= '0;
            buf_pio <= 1'b0;
            buf_read <= 1'b0;
            mux_pend <= 1'b0;
            disp_valid <= 1'b0;
            loading <= 1'b0;
        end
        else
        begin
            loading <= wr_pio_data | from_disp | from_mux;
            if (wr_pio_data)
            begin
                buf_data <= wb_dat_i[DATA_W-1:0];
                buf_tag <= pio_tag[8:0];
                buf_pio <= 1'b1;
                buf_read <= 1'b0;
                if (preempt)
                begin
                    disp_data <= buf_data;
                    disp_tag <= buf_tag;
                    disp_valid <= 1'b1;
                end
            end
            else if (from_disp)
            begin
                buf_data <= disp_data;
                buf_tag <= disp_tag;
                buf_pio <= 1'b0;
                buf_read <= 1'b0;
                disp_valid <= 1'b0;
            end
            else if (from_mux)
            begin
                buf_data <= mux_data;
                buf_tag <= mux_tag[8:0];
                buf_pio <= 1'b0;
                buf_read <= 1'b0;
            end
            else if (strobe_rise)
                buf_read <= 1'b1;
            if (wr_mux_data)
            begin
                mux_data <= wb_dat_i[DATA_W-1:0];
                mux_pend <= 1'b1;
            end
            else if (from_mux)
                mux_pend <= 1'b0;
        end
    end

    // Ground and telemetry output words, all registered.
    wire [TAG_W-1:0] tag_word = {buf_tag[ADDR_W-1:0], buf_pio};
    wire chk_addr = buf_tag[TAG_CHK_BIT];
    wire [TLM_MODE_W-1:0] next_tlm_mode = buf_pio ? mode_f[TLM_MODE_W-1:0] : rt_f[4:2];
    wire next_tlm_shared = buf_pio ? buf_tag[TAG_A1_BIT] : rt_f[1];
    wire next_tlm_valid = buf_pio ? ~(loading | chk_addr) : rt_f[5];

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            transfer_handshake_reset_o <= 1'b0;
            prelaunch_mode_o <= 1'b0;
            guidance_failure_flag_o <= 1'b0;
            ground_word_o <= '0;
            ground_tag_o <= '0;
            ground_mode_o <= '0;
            ground_real_time_o <= 1'b0;
            tlm_word_o <= '0;
            tlm_tag_o <= '0;
            tlm_tag_shared_bit_o <= 1'b0;
            tlm_mode_rt_o <= '0;
            tlm_valid_rt_o <= 1'b0;
        end
        else
        begin
            transfer_handshake_reset_o <= next_hs_state == HS_HOLD && !init_s;
            prelaunch_mode_o <= prelaunch;
            guidance_failure_flag_o <= ctrl[CTRL_GFAIL];
            ground_word_o <= buf_data;
            ground_tag_o <= tag_word;
            ground_mode_o <= mode_f;
            ground_real_time_o <= rt_f[0];
            tlm_word_o <= buf_data;
            tlm_tag_o <= tag_word;
            tlm_tag_shared_bit_o <= next_tlm_shared;
            tlm_mode_rt_o <= next_tlm_mode;
            tlm_valid_rt_o <= next_tlm_valid;
        end
    end

    // Register read-back; unmapped addresses read as zero and still acknowledge.
    wire [31:0] status_word = 32'(
        (hs_state == HS_HOLD) << ST_HS | started << ST_STARTED
        | mode_valid << ST_MODE_VALID | prelaunch << ST_PRELAUNCH
        | alert_seen << ST_ALERT | buf_pio << ST_SRC_PIO | mux_pend << ST_MUX_PEND
        | disp_valid << ST_DISPLACED | init_s << ST_INIT | select_s << ST_SELECT
        | (hs_state == HS_ARMED) << ST_ARMED);
    wire [31:0] rdata =
        wb_adr_i == ADR_CTRL ? ctrl :
        wb_adr_i == ADR_MODE_RT ? mode_rt :
        wb_adr_i == ADR_MUX_TAG ? mux_tag :
        wb_adr_i == ADR_MUX_DATA ? 32'(mux_data) :
        wb_adr_i == ADR_PIO_TAG ? pio_tag :
        wb_adr_i == ADR_PIO_DATA ? 32'(buf_data) :
        wb_adr_i == ADR_STATUS ? status_word :
        wb_adr_i == ADR_GROUND ? 32'(gword) : 32'h0;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
                wb_dat_o <= rdata;
        end
    end
endmodule // gdop_top

/* rtl/gdop_pkg.sv */
// Constants, register map and state type of the ground data output port.
// Assumes a single 50 MHz clock and a 32-bit classic Wishbone register bus.
package gdop_pkg;
    localparam int DATA_W = 26;
    localparam int ADDR_W = 7;
    localparam int TAG_W = 8;
    localparam int MODE_W = 6;
    localparam int TLM_MODE_W = 3;
    localparam int RT_W = 6;
    localparam int GDATA_W = 14;
    localparam int INFO_W = 13;
    localparam int FLAG_BIT = 13;
    localparam int WB_ADR_W = 8;
    localparam int SYNC_W = 7 + 2 * GDATA_W;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_MODE_RT = 8'h04;
    localparam logic [7:0] ADR_MUX_TAG = 8'h08;
    localparam logic [7:0] ADR_MUX_DATA = 8'h0c;
    localparam logic [7:0] ADR_PIO_TAG = 8'h10;
    localparam logic [7:0] ADR_PIO_DATA = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;
    localparam logic [7:0] ADR_GROUND = 8'h1c;

    localparam int CTRL_GFAIL = 0;
    localparam int CTRL_READOUT = 1;
    localparam int CTRL_GO = 2;
    localparam int RT_LSB = 8;
    localparam int TAG_A1_BIT = 7;
    localparam int TAG_CHK_BIT = 8;

    localparam int ST_HS = 0;
    localparam int ST_STARTED = 1;
    localparam int ST_MODE_VALID = 2;
    localparam int ST_PRELAUNCH = 3;
    localparam int ST_ALERT = 4;
    localparam int ST_SRC_PIO = 5;
    localparam int ST_MUX_PEND = 6;
    localparam int ST_DISPLACED = 7;
    localparam int ST_INIT = 8;
    localparam int ST_SELECT = 9;
    localparam int ST_ARMED = 10;

    localparam int HS_DELAY_MS = 5;
    localparam int CLK_HZ = 50_000_000;
    localparam int HS_CYCLES = HS_DELAY_MS * (CLK_HZ / 1000);
    localparam int HS_CNT_W = 18;

    typedef enum logic [1:0] {HS_IDLE, HS_ARMED, HS_HOLD} gdop_hs_t;
endpackage

/* test/gdop_sva.sv */
// Checker for the ground data output port, watching top-level ports only.
// Assumes one clock domain and the hold count handed on by the bind.
`timescale 1ns/1ps
module gdop_sva
    import gdop_pkg::*;
#(
    parameter int HS_HOLD_CYCLES = 8
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [gdop_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic initialise_i,
    input wire logic command_source_select_i,
    input wire logic ground_sync_bit_i,
    input wire logic command_sync_i,
    input wire logic release_alert_i,
    input wire logic transfer_handshake_reset_o,
    input wire logic prelaunch_mode_o,
    input wire logic guidance_failure_flag_o,
    input wire logic [gdop_pkg::DATA_W-1:0] ground_word_o,
    input wire logic [gdop_pkg::TAG_W-1:0] ground_tag_o,
    input wire logic [gdop_pkg::DATA_W-1:0] tlm_word_o,
    input wire logic [gdop_pkg::TAG_W-1:0] tlm_tag_o,
    input wire logic tlm_valid_rt_o
);
    logic [17:0] hs_cnt;
    logic alert_seen;
    logic ctrl_wr;
    logic go_wr;
    assign ctrl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0];
    assign go_wr = ctrl_wr && wb_dat_i[CTRL_GO];
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hs_cnt <= '0;
            alert_seen <= 1'b0;
        end
        else
        begin
            hs_cnt <= transfer_handshake_reset_o ? hs_cnt + 18'h1 : 18'h0;
            alert_seen <= !initialise_i && (alert_seen || release_alert_i);
        end
    end
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_hs_len: assert property (disable iff (!rst_n_i || initialise_i)
        $fell(transfer_handshake_reset_o) |-> hs_cnt == HS_HOLD_CYCLES)
        else $error("handshake hold length wrong");
    a_hs_bound: assert property (disable iff (!rst_n_i || initialise_i)
        transfer_handshake_reset_o |-> hs_cnt < HS_HOLD_CYCLES)
        else $error("handshake held too long");
    a_hs_cause: assert property (disable iff (!rst_n_i || initialise_i)
        $rose(transfer_handshake_reset_o) |->
        (!command_source_select_i && ground_sync_bit_i) ||
        (command_source_select_i && command_sync_i) ||
        $past(go_wr) || $past(go_wr, 2) || $past(go_wr, 3))
        else $error("handshake without sync or start");
    a_pre_sticky: assert property (disable iff (!rst_n_i || initialise_i)
        prelaunch_mode_o |=> prelaunch_mode_o)
        else $error("prelaunch dropped");
    a_pre_alert: assert property ($rose(prelaunch_mode_o) |-> alert_seen)
        else $error("prelaunch without alert");
    a_pio_inval: assert property (
        $changed(tlm_word_o) && tlm_tag_o[0] |-> !tlm_valid_rt_o)
        else $error("new computer word shown valid");
    a_same_word: assert property (
        ground_word_o == tlm_word_o && ground_tag_o == tlm_tag_o)
        else $error("ground and telemetry words differ");
    a_gfail_set: assert property (
        ctrl_wr && !wb_ack_o && wb_dat_i[CTRL_GFAIL] && !initialise_i
        |-> ##[1:3] guidance_failure_flag_o)
        else $error("guidance failure not raised");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_resp: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    c_hold: cover property ($rose(transfer_handshake_reset_o));
    c_pre: cover property ($rose(prelaunch_mode_o));
    c_pio: cover property ($rose(tlm_tag_o[0]));
    c_mux: cover property ($fell(tlm_tag_o[0]));
endmodule // gdop_sva

bind gdop_top gdop_sva #(.HS_HOLD_CYCLES(HS_HOLD_CYCLES)) u_sva (
    .ref_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_ack_o, .initialise_i, .command_source_select_i,
    .ground_sync_bit_i, .command_sync_i, .release_alert_i,
    .transfer_handshake_reset_o, .prelaunch_mode_o, .guidance_failure_flag_o,
    .ground_word_o, .ground_tag_o, .tlm_word_o, .tlm_tag_o, .tlm_valid_rt_o
);

/* test/gdop_ground_model.sv */
// Model of the ground checkout equipment on the pin side of the port.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module gdop_ground_model
(
    input wire logic clk_i,
    input wire logic hs_i,
    output logic sync_o,
    output logic strobe_o,
    output logic alert_o,
    output logic release_o,
    output logic [13:0] data_o
);
    initial
    begin
        sync_o = 1'b0;
        strobe_o = 1'b0;
        alert_o = 1'b0;
        release_o = 1'b0;
        data_o = 14'h0;
    end
    // Sync stays up until the handshake reset answers or 40 cycles pass; data then turns to its inverse.
    task automatic send_word(input logic [13:0] w);
        int n;
        @(posedge clk_i);
        data_o <= w;
        sync_o <= 1'b1;
        n = 0;
        do
            @(posedge clk_i);
        while (hs_i !== 1'b1 && ++n < 40);
        sync_o <= 1'b0;
        data_o <= ~w;
    endtask
    task automatic read_word();
        @(posedge clk_i);
        strobe_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        strobe_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic release_cmd(input logic alert);
        @(posedge clk_i);
        alert_o <= alert;
        repeat (4) @(posedge clk_i);
        release_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        release_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
endmodule // gdop_ground_model

/* test/tb_top.sv */
// Self-checking bench for the ground data output port.
// Assumes the ground model drives the ground pins; the bench owns the bus.
`timescale 1ns/1ps
module tb_top;
    import gdop_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, init = 1'b0, src = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic cmd_sync = 1'b0;
    logic [13:0] cmd_data = 14'h0, gdata;
    logic sync, strobe, alert, rel, hs, pre, gfail, grt, tshared, tvalid;
    logic [25:0] gword, tword;
    logic [7:0] gtag, ttag;
    logic [5:0] gmode;
    logic [2:0] tmrt;
    int err_count = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    gdop_top #(.HS_HOLD_CYCLES(8)) u_dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .initialise_i(init), .command_source_select_i(src), .word_read_strobe_i(strobe),
        .ground_sync_bit_i(sync), .release_alert_i(alert),
        .guidance_reference_release_i(rel), .ground_data_i(gdata),
        .command_sync_i(cmd_sync), .command_data_i(cmd_data),
        .transfer_handshake_reset_o(hs), .prelaunch_mode_o(pre),
        .guidance_failure_flag_o(gfail), .ground_word_o(gword), .ground_tag_o(gtag),
        .ground_mode_o(gmode), .ground_real_time_o(grt), .tlm_word_o(tword),
        .tlm_tag_o(ttag), .tlm_tag_shared_bit_o(tshared), .tlm_mode_rt_o(tmrt),
        .tlm_valid_rt_o(tvalid)
    );
    gdop_ground_model u_gm (
        .clk_i(clk), .hs_i(hs), .sync_o(sync), .strobe_o(strobe), .alert_o(alert),
        .release_o(rel), .data_o(gdata)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do
            @(posedge clk);
        while (ack !== 1'b1 && ++n < 20);
        if (n >= 20)
            err_count++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_hs(input logic v);
        int n;
        n = 0;
        while (hs !== v && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(hs), 32'(v));
    endtask
    task automatic t_regs();
        wb(1'b1, ADR_MODE_RT, 32'h2d2a);
        wb(1'b0, ADR_MODE_RT, 32'h0);
        chk(q, 32'h2d2a);
        chk(32'(gmode), 32'h2a);
        chk(32'(grt), 32'h1);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_loadin();
        u_gm.send_word(14'h2abc);
        chk(32'(hs), 32'h1);
        wait_hs(1'b0);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(32'(q[2:1]), 32'h3);
        wb(1'b0, ADR_GROUND, 32'h0);
        chk(q, 32'h2abc);
    endtask
    task automatic t_readout();
        wb(1'b1, ADR_CTRL, 32'h2);
        wb(1'b1, ADR_STATUS, 32'h2);
        u_gm.send_word(14'h0abc);
        chk(32'(hs), 32'h0);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(q & 32'h402, 32'h400);
        wb(1'b1, ADR_CTRL, 32'h6);
        @(posedge clk);
        chk(32'(hs), 32'h1);
        wait_hs(1'b0);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(q & 32'h403, 32'h002);
        wb(1'b1, ADR_CTRL, 32'h0);
    endtask
    task automatic t_select();
        src <= 1'b1;
        repeat (4) @(posedge clk);
        u_gm.send_word(14'h0111);
        chk(32'(hs), 32'h0);
        cmd_data <= 14'h1234;
        cmd_sync <= 1'b1;
        wait_hs(1'b1);
        cmd_sync <= 1'b0;
        cmd_data <= ~14'h1234;
        chk(32'(hs), 32'h1);
        wait_hs(1'b0);
        wb(1'b0, ADR_GROUND, 32'h0);
        chk(q, 32'h1234);
        src <= 1'b0;
    endtask
    task automatic t_mux();
        wb(1'b1, ADR_MUX_TAG, 32'h33);
        wb(1'b1, ADR_MUX_DATA, 32'h1abcdef);
        u_gm.read_word();
        chk(32'(gword), 32'h1abcdef);
        chk(32'(gtag), 32'h66);
        chk(32'({tshared, tmrt, tvalid}), 32'h07);
        wb(1'b1, ADR_MUX_DATA, 32'h2000001);
        wb(1'b1, ADR_PIO_TAG, 32'hd5);
        wb(1'b1, ADR_PIO_DATA, 32'h0123456);
        repeat (2) @(posedge clk);
        chk(32'(tword), 32'h0123456);
        chk(32'(ttag), 32'hab);
        chk(32'({tshared, tmrt, tvalid}), 32'h15);
        u_gm.read_word();
        chk(32'(gword), 32'h1abcdef);
        chk(32'(gtag), 32'h66);
        u_gm.read_word();
        chk(32'(gword), 32'h2000001);
        wb(1'b1, ADR_PIO_TAG, 32'h155);
        wb(1'b1, ADR_PIO_DATA, 32'h0000abc);
        repeat (3) @(posedge clk);
        chk(32'(tvalid), 32'h0);
    endtask
    task automatic t_release();
        u_gm.release_cmd(1'b0);
        chk(32'(pre), 32'h0);
        u_gm.release_cmd(1'b1);
        chk(32'(pre), 32'h1);
        wb(1'b1, ADR_CTRL, 32'h1);
        @(posedge clk);
        chk(32'(gfail), 32'h1);
    endtask
    task automatic t_init();
        init <= 1'b1;
        repeat (6) @(posedge clk);
        chk(32'({pre, gfail}), 32'h0);
        chk(32'(gword), 32'h0);
        init <= 1'b0;
        repeat (4) @(posedge clk);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(q & 32'h8f, 32'h0);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_loadin();
        t_readout();
        t_select();
        t_mux();
        t_release();
        t_init();
        results();
    end
    initial
    begin
        #100000;
        err_count++;
        results();
    end
endmodule // tb_top
